//--- logic/dsw_encoder.sv
`timescale 1ns/1ns
// Behaviour
// - position mode: bit 11 set while a stroke-end limit is reached
// - homing mode: bit 12 set once home return completed
// - homing mode: bit 13 set while a home return failure exists
// - position mode: bit 13 set when following error persists past timeout
// - homing bits 13,12,10 encode progress: 000,001,011,101
// - bit 7 set while any warning or alarm present
// - bit 9 reports whether control through control word is enabled
// - control word enabled only in network mode with command origin zero
// - ethernet commands accepted only when network port is selected
// - not-ready state: bits 6,3,2,1,0 all zero
// - switch-on-disabled: bit 6 set, bits 3..0 zero
// - ready 1x0001, switched on 1x0011, enabled 1x0111, fast halt 0x0111
// - fault reaction: bits 3..0 set; fault: bit 3 only
// - position mode: bit 10 set after position in window for window time
// - homing bit 10: not busy when no failure, else ideal speed zero
module dsw_encoder #(
  parameter int unsigned POS_WIN_CYC = dsw_pkg::POS_WIN_CYC_DEF,
  parameter int unsigned FOL_TO_CYC  = dsw_pkg::FOL_TO_CYC_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       clk_en,
  input  wire dsw_pkg::dsw_mode_e         ctrl_mode,
  input  wire dsw_pkg::dsw_state_e        drive_state,
  input  wire logic                       fast_halt_flag_bit,
  input  wire dsw_pkg::dsw_pins_s         pins,
  input  wire dsw_pkg::dsw_cfg_s          cfg,
  input  wire logic                       pos_in_window,
  input  wire logic                       fol_over_window,
  output logic [dsw_pkg::WORD_W-1:0]      drive_state_report_word,
  output logic                            network_control_flag,
  output logic                            cmd_accept
);

  // the 16-bit timers cannot count past 65535, and a zero window would hold its status bit set at all times
  if (POS_WIN_CYC < 1 || POS_WIN_CYC > 65535 || FOL_TO_CYC < 1 || FOL_TO_CYC > 65535)
  begin : g_bad_window
    $error("dsw_encoder: window counts out of range");
  end

  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // pins come from outside the clock domain: two-stage synchronisers
  dsw_pkg::dsw_pins_s pins_s1_q;
  dsw_pkg::dsw_pins_s pins_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_s1_q <= '0;
      pins_q    <= '0;
    end
    else if (clk_en)
    begin
      pins_s1_q <= pins;
      pins_q    <= pins_s1_q;
    end
  end

  // window timers, saturating
  logic [15:0] pos_cnt_q;
  logic [15:0] pos_cnt_d;
  logic [15:0] fol_cnt_q;
  logic [15:0] fol_cnt_d;
  logic        goal_d;
  logic        fol_d;
  localparam logic [15:0] POS_LIM = 16'(POS_WIN_CYC);
  localparam logic [15:0] FOL_LIM = 16'(FOL_TO_CYC);

  always_comb
  begin
    pos_cnt_d = pos_cnt_q;
    fol_cnt_d = fol_cnt_q;
    if (!pos_in_window)
      pos_cnt_d = 16'h0000;
    else if (pos_cnt_q < POS_LIM)
      pos_cnt_d = pos_cnt_q + 16'h0001;
    if (!fol_over_window)
      fol_cnt_d = 16'h0000;
    else if (fol_cnt_q < FOL_LIM)
      fol_cnt_d = fol_cnt_q + 16'h0001;
    goal_d = (pos_cnt_q == POS_LIM);
    fol_d  = (fol_cnt_q == FOL_LIM);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_cnt_q <= 16'h0000;
      fol_cnt_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      pos_cnt_q <= pos_cnt_d;
      fol_cnt_q <= fol_cnt_d;
    end
  end

  // word assembly
  logic [15:0] word_d;
  logic        net_d;
  logic        acc_d;

  always_comb
  begin
    word_d = dsw_pkg::WORD_RST;
    // port select gates acceptance; origin zero also needed for control word
    acc_d = cfg.network_run_mode && cfg.net_command_port_select;
    net_d = acc_d && (cfg.command_origin_select == dsw_pkg::CMD_ORIGIN_NET);
    case (drive_state)
      dsw_pkg::DSW_ST_NOT_READY:
        word_d[dsw_pkg::BIT_SOD] = 1'b0;
      dsw_pkg::DSW_ST_SWON_DIS:
        word_d[dsw_pkg::BIT_SOD] = 1'b1;
      dsw_pkg::DSW_ST_READY:
      begin
        word_d[dsw_pkg::BIT_RTSO]  = 1'b1;
        word_d[dsw_pkg::BIT_FHALT] = 1'b1;
      end
      dsw_pkg::DSW_ST_SWITCHED_ON:
      begin
        word_d[dsw_pkg::BIT_RTSO]  = 1'b1;
        word_d[dsw_pkg::BIT_SO]    = 1'b1;
        word_d[dsw_pkg::BIT_FHALT] = 1'b1;
      end
      dsw_pkg::DSW_ST_OP_EN, dsw_pkg::DSW_ST_FAST_HALT:
      begin
        word_d[dsw_pkg::BIT_RTSO]  = 1'b1;
        word_d[dsw_pkg::BIT_SO]    = 1'b1;
        word_d[dsw_pkg::BIT_OE]    = 1'b1;
        word_d[dsw_pkg::BIT_FHALT] = (drive_state == dsw_pkg::DSW_ST_OP_EN);
      end
      dsw_pkg::DSW_ST_FAULT_REACT:
      begin
        word_d[dsw_pkg::BIT_RTSO]  = 1'b1;
        word_d[dsw_pkg::BIT_SO]    = 1'b1;
        word_d[dsw_pkg::BIT_OE]    = 1'b1;
        word_d[dsw_pkg::BIT_FAULT] = 1'b1;
      end
      dsw_pkg::DSW_ST_FAULT:
        word_d[dsw_pkg::BIT_FAULT] = 1'b1;
      default:
        word_d[dsw_pkg::BIT_SOD] = 1'b0;
    endcase
    // bit 5 is don't-care in unstable states; driven from the fast halt input there
    if (drive_state inside {dsw_pkg::DSW_ST_NOT_READY, dsw_pkg::DSW_ST_SWON_DIS,
                            dsw_pkg::DSW_ST_FAULT_REACT, dsw_pkg::DSW_ST_FAULT})
      word_d[dsw_pkg::BIT_FHALT] = fast_halt_flag_bit;
    word_d[dsw_pkg::BIT_WARN] = pins_q.warn_or_alarm;
    word_d[dsw_pkg::BIT_NET]  = net_d;
    case (ctrl_mode)
      dsw_pkg::DSW_MODE_POSITION:
      begin
        word_d[dsw_pkg::BIT_LIMIT] = pins_q.stroke_limit_signal;
        word_d[dsw_pkg::BIT_GOAL]  = goal_d;
        word_d[dsw_pkg::BIT_HFAIL] = fol_d;
      end
      dsw_pkg::DSW_MODE_HOMING:
      begin
        word_d[dsw_pkg::BIT_LIMIT] = pins_q.stroke_limit_signal;
        word_d[dsw_pkg::BIT_HDONE] = pins_q.homing_done_signal;
        word_d[dsw_pkg::BIT_HFAIL] = pins_q.homing_fail_signal;
        // failure takes precedence over the busy indication
        word_d[dsw_pkg::BIT_GOAL]  = pins_q.homing_fail_signal ? pins_q.ideal_speed_zero
                                                               : !pins_q.positioning_active_signal;
      end
      default:
        word_d[dsw_pkg::BIT_LIMIT] = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_state_report_word <= dsw_pkg::WORD_RST;
      network_control_flag    <= 1'b0;
      cmd_accept              <= 1'b0;
    end
    else if (clk_en)
    begin
      drive_state_report_word <= word_d;
      network_control_flag    <= net_d;
      cmd_accept              <= acc_d;
    end
  end

  // checks
  logic pos_mode_q;
  logic hom_mode_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_mode_q <= 1'b0;
      hom_mode_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pos_mode_q <= (ctrl_mode == dsw_pkg::DSW_MODE_POSITION);
      hom_mode_q <= (ctrl_mode == dsw_pkg::DSW_MODE_HOMING);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_limit_bit_follows: assert property (clk_en && pos_mode_q |-> drive_state_report_word[11] == pins_q.stroke_limit_signal || !$stable(pins_q)) else $error("limit bit wrong");
  a_home_done_bit: assert property (hom_mode_q && $stable(pins_q) && $past(clk_en) |-> drive_state_report_word[12] == pins_q.homing_done_signal) else $error("home done bit wrong");
  a_home_fail_bit: assert property (hom_mode_q && $stable(pins_q) && $past(clk_en) |-> drive_state_report_word[13] == pins_q.homing_fail_signal) else $error("home fail bit wrong");
  a_home_combo: assert property (hom_mode_q && $past(clk_en) |-> drive_state_report_word[13:12] != 2'b11 || !$stable(pins_q) || pins_q.homing_done_signal) else $error("homing combo wrong");
  a_warn_bit: assert property (clk_en && $stable(pins_q) && $past(clk_en) |-> drive_state_report_word[7] == pins_q.warn_or_alarm) else $error("warn bit wrong");
  a_net_flag_match: assert property (drive_state_report_word[9] == network_control_flag) else $error("net flag mismatch");
  a_net_needs_accept: assert property (network_control_flag |-> cmd_accept) else $error("net flag without accept");
  a_fault_pattern: assert property (clk_en && drive_state == dsw_pkg::DSW_ST_FAULT ##1 1 |-> drive_state_report_word[3:0] == 4'h8) else $error("fault pattern wrong");
  a_sod_pattern: assert property (clk_en && drive_state == dsw_pkg::DSW_ST_SWON_DIS ##1 1 |-> drive_state_report_word[6] && drive_state_report_word[3:0] == 4'h0) else $error("sod pattern wrong");
  a_unused_zero: assert property (drive_state_report_word[15:14] == 2'h0 && drive_state_report_word[8] == 1'b0 && drive_state_report_word[4] == 1'b0) else $error("unused bits set");

  c_fault: cover property (drive_state_report_word[3:0] == 4'h8);
  c_op_en: cover property (drive_state_report_word[6:0] == 7'h27);
  c_home_done: cover property (drive_state_report_word[13:12] == 2'h1);
  c_goal: cover property (pos_mode_q && drive_state_report_word[10]);

endmodule // dsw_encoder

//--- logic/dsw_pkg.sv
package dsw_pkg;

  localparam int unsigned WORD_W = 16;

  // status word bit positions
  localparam int unsigned BIT_RTSO  = 0;
  localparam int unsigned BIT_SO    = 1;
  localparam int unsigned BIT_OE    = 2;
  localparam int unsigned BIT_FAULT = 3;
  localparam int unsigned BIT_FHALT = 5;
  localparam int unsigned BIT_SOD   = 6;
  localparam int unsigned BIT_WARN  = 7;
  localparam int unsigned BIT_NET   = 9;
  localparam int unsigned BIT_GOAL  = 10;
  localparam int unsigned BIT_LIMIT = 11;
  localparam int unsigned BIT_HDONE = 12;
  localparam int unsigned BIT_HFAIL = 13;

  localparam logic [15:0] WORD_RST      = 16'h0000;
  localparam logic [1:0]  CMD_ORIGIN_NET = 2'h0;

  // timing defaults in cycles of clk with clk_en high
  localparam int unsigned POS_WIN_CYC_DEF = 16;
  localparam int unsigned FOL_TO_CYC_DEF  = 16;

  typedef enum logic [1:0] {
    DSW_MODE_POSITION,
    DSW_MODE_HOMING,
    DSW_MODE_SPEED,
    DSW_MODE_TORQUE
  } dsw_mode_e;

  typedef enum logic [2:0] {
    DSW_ST_NOT_READY,
    DSW_ST_SWON_DIS,
    DSW_ST_READY,
    DSW_ST_SWITCHED_ON,
    DSW_ST_OP_EN,
    DSW_ST_FAST_HALT,
    DSW_ST_FAULT_REACT,
    DSW_ST_FAULT
  } dsw_state_e;

  typedef struct packed {
    logic stroke_limit_signal;
    logic homing_done_signal;
    logic homing_fail_signal;
    logic positioning_active_signal;
    logic ideal_speed_zero;
    logic warn_or_alarm;
  } dsw_pins_s;

  typedef struct packed {
    logic network_run_mode;
    logic net_command_port_select;
    logic [1:0] command_origin_select;
  } dsw_cfg_s;

endpackage

//--- dv/dsw_ctrl_model.sv
`timescale 1ns/1ns
// controller side: decodes the drive state from the status word
module dsw_ctrl_model (
  input  wire logic [15:0]         word,
  output dsw_pkg::dsw_state_e      state
);
  // bit 5 is ignored where it carries no meaning
  always_comb
  begin
    casez ({word[6:5], word[3:0]})
      6'b0?0000: state = dsw_pkg::DSW_ST_NOT_READY;
      6'b1?0000: state = dsw_pkg::DSW_ST_SWON_DIS;
      6'b010001: state = dsw_pkg::DSW_ST_READY;
      6'b010011: state = dsw_pkg::DSW_ST_SWITCHED_ON;
      6'b010111: state = dsw_pkg::DSW_ST_OP_EN;
      6'b000111: state = dsw_pkg::DSW_ST_FAST_HALT;
      6'b0?1111: state = dsw_pkg::DSW_ST_FAULT_REACT;
      6'b0?1000: state = dsw_pkg::DSW_ST_FAULT;
      default:   state = dsw_pkg::DSW_ST_NOT_READY;
    endcase
  end
endmodule // dsw_ctrl_model

//--- dv/drive_status_word_encoder_test.sv
`timescale 1ns/1ns
module drive_status_word_encoder_test;
  logic                 clk, nrst, clk_en, fh, pin, fol, flag, acc;
  dsw_pkg::dsw_mode_e   mode;
  dsw_pkg::dsw_state_e  state, seen_st;
  dsw_pkg::dsw_pins_s   pins;
  dsw_pkg::dsw_cfg_s    cfg;
  logic [15:0]          word, held;
  int                   err_count, checked, seed;

  dsw_encoder #(.POS_WIN_CYC(2), .FOL_TO_CYC(2)) uut (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .ctrl_mode(mode), .drive_state(state),
    .fast_halt_flag_bit(fh), .pins(pins), .cfg(cfg), .pos_in_window(pin), .fol_over_window(fol),
    .drive_state_report_word(word), .network_control_flag(flag), .cmd_accept(acc));
  dsw_ctrl_model ctrl (.word(word), .state(seen_st));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [15:0] exp_word();
    logic [15:0] w;
    w = 16'h0000;
    case (state)
      dsw_pkg::DSW_ST_NOT_READY:    w[6:0] = {1'h0, fh, 5'h00};
      dsw_pkg::DSW_ST_SWON_DIS:     w[6:0] = {1'h1, fh, 5'h00};
      dsw_pkg::DSW_ST_READY:        w[6:0] = 7'h21;
      dsw_pkg::DSW_ST_SWITCHED_ON:  w[6:0] = 7'h23;
      dsw_pkg::DSW_ST_OP_EN:        w[6:0] = 7'h27;
      dsw_pkg::DSW_ST_FAST_HALT:    w[6:0] = 7'h07;
      dsw_pkg::DSW_ST_FAULT_REACT:  w[6:0] = {1'h0, fh, 5'h0f};
      default:                      w[6:0] = {1'h0, fh, 5'h08};
    endcase
    w[7] = pins.warn_or_alarm;
    w[9] = cfg.network_run_mode & cfg.net_command_port_select & (cfg.command_origin_select == 2'h0);
    if (mode == dsw_pkg::DSW_MODE_POSITION)
      w[13:10] = {fol, 1'h0, pins.stroke_limit_signal, pin};
    else if (mode == dsw_pkg::DSW_MODE_HOMING)
      w[13:10] = {pins.homing_fail_signal, pins.homing_done_signal, pins.stroke_limit_signal,
                  pins.homing_fail_signal ? pins.ideal_speed_zero : ~pins.positioning_active_signal};
    return w;
  endfunction

  // inputs held 8 cycles so the 2-flop pin sync and the window timers settle
  task automatic apply(input logic [1:0] m, input logic [2:0] s);
    @(negedge clk);
    mode = dsw_pkg::dsw_mode_e'(m);
    state = dsw_pkg::dsw_state_e'(s);
    {fh, pin, fol} = 3'($random(seed));
    pins = 6'($random(seed));
    cfg = 4'($random(seed));
    if (seed[3])
      cfg.command_origin_select = 2'h0;
    repeat (8) @(negedge clk);
    check("word", word, exp_word());
    check("remote", 16'(flag), 16'(word[9]));
    check("accept", 16'(acc), 16'(cfg.network_run_mode & cfg.net_command_port_select));
    if (word[6:0] != 7'h07 || state == dsw_pkg::DSW_ST_FAST_HALT)
      check("decoded state", 16'(seen_st), 16'(state));
  endtask

  initial
  begin
    seed = 32'h63ec814b;
    {nrst, clk_en, fh, pin, fol, pins, cfg} = '0;
    mode = dsw_pkg::DSW_MODE_POSITION;
    state = dsw_pkg::DSW_ST_NOT_READY;
    err_count = 0;
    checked = 0;
    repeat (3) @(negedge clk);
    check("reset word", word, 16'h0000);
    nrst = 1'h1;
    clk_en = 1'h1;
    for (int i = 0; i < 32; i++)
      apply(i[4:3], i[2:0]);
    for (int i = 0; i < 150; i++)
      apply(2'($random(seed)), 3'($random(seed)));
    // a window shorter than the timeout must not set bits 10 and 13
    apply(2'h0, 3'h4);
    pin = 1'h1;
    fol = 1'h1;
    @(negedge clk);
    {pin, fol} = 2'h0;
    repeat (8) @(negedge clk);
    check("short window", word & 16'h2400, 16'h0000);
    // clk_en low freezes the word whatever the inputs do
    held = word;
    clk_en = 1'h0;
    state = dsw_pkg::DSW_ST_FAULT;
    pins = 6'h3f;
    repeat (8) @(negedge clk);
    check("frozen word", word, held);
    clk_en = 1'h1;
    nrst = 1'h0;
    @(negedge clk);
    check("mid reset word", word, 16'h0000);
    nrst = 1'h1;
    apply(2'h1, 3'h6);
    results();
  end

  initial
  begin
    #100000;
    err_count++;
    results();
  end
endmodule // drive_status_word_encoder_test
